// [debug_flags_pkg.sv]
// constants, register map and carrier types of the debug status flag block
package debug_flags_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register indices as printed; byte address is four times the index
	localparam logic [7:0]  IDX_STATUS_SECOND = 8'h02;
	localparam logic [7:0]  IDX_DEBUG_ADDRESS = 8'h04;
	localparam logic [7:0]  IDX_IRQ_STATUS    = 8'h08;
	localparam logic [7:0]  IDX_IRQ_MASK      = 8'h09;

	////////////////////////////////////////////////////////////////////////////////
	// field positions of the second status register
	localparam int          BIT_PROTECTED     = 0;
	localparam int          BIT_PROBE         = 1;
	localparam int          BIT_DIRTY0        = 2;
	localparam int          BIT_DIRTY1        = 3;
	localparam int          BIT_HOT_PLUG      = 4;
	localparam int          STATUS_WIDTH      = 8;

	// event bits of the interrupt status and mask registers
	localparam int          EVT_PROBE         = 0;
	localparam int          EVT_HOT_PLUG_LOST = 1;
	localparam int          EVT_DIRTY0        = 2;
	localparam int          EVT_COUNT         = 4;

	////////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic        RESET_HOT_PLUG    = 1'b1;
	localparam logic [31:0] RESET_ADDRESS     = 32'h0000_0000;
	localparam logic [3:0]  RESET_IRQ         = 4'h0;

	// cycles the synchronised protection input needs before it is captured
	localparam logic [1:0]  PROTECTED_STATE_CAPTURE_WAIT = 2'h2;

	// bus answers
	localparam logic [1:0]  RESP_OKAY         = 2'h0;
	localparam logic [1:0]  RESP_SLVERR       = 2'h2;
	localparam int          CHANNEL_COUNT     = 2;

	////////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic       hot_plug_enabled;
		logic [1:0] channel_dirty;
		logic       probe_present;
		logic       protected_state;
	} status_flags_type;

	typedef struct packed {
		logic [1:0] write_strobe;
		logic [1:0] read_strobe;
	} channel_strobe_type;

endpackage : debug_flags_pkg

// [debug_status_flags.sv]
// debug status flags with AXI4-Lite register access and interrupt
//
// What this block does
// - the hot-plug flag in bit 4 of the second status register reads one while hot-plugging is enabled.
// - the hot-plug flag is cleared as soon as the serial wire clock pin is given another function.
// - once cleared, the hot-plug flag is set again only by power-on or external reset, never by software.
// - the probe-present flag in bit 1 sets when a debug probe is detected and is cleared only by power-on or external reset.
// - the protected flag in bit 0 is loaded after power-on or external reset from the protection state and held until the next such reset.
// - each channel dirty flag, bits 3 and 2, sets whenever its channel data register is written without a module reset in the same cycle.
// - each channel dirty flag clears whenever its channel data register is read in a cycle with no write to it.
// - writes to the second status register are ignored; flags move only by hardware.
// - the second status register sits at index 0x0002 with the hot-plug flag resetting to one.
`timescale 1ns/10ps
`default_nettype none

module debug_status_flags
#(
	parameter int ADDR_WIDTH = 8
)
(
	// clock and reset (power-on or external)
	input  wire logic                                  clk_in,
	input  wire logic                                  rst_n_in,
	// module reset from the control register
	input  wire logic                                  module_reset_in,
	// asynchronous conditions
	input  wire logic                                  probe_detected_in,
	input  wire logic                                  protected_device_in,
	input  wire logic                                  swclk_function_changed_in,
	// channel data register strobes
	input  wire debug_flags_pkg::channel_strobe_type   channel_strobe_in,
	// axi4-lite write address
	input  wire logic [ADDR_WIDTH-1:0]                 s_axi_awaddr_in,
	input  wire logic                                  s_axi_awvalid_in,
	output logic                                       s_axi_awready_out,
	// axi4-lite write data
	input  wire logic [31:0]                           s_axi_wdata_in,
	input  wire logic [3:0]                            s_axi_wstrb_in,
	input  wire logic                                  s_axi_wvalid_in,
	output logic                                       s_axi_wready_out,
	// axi4-lite write response
	output logic [1:0]                                 s_axi_bresp_out,
	output logic                                       s_axi_bvalid_out,
	input  wire logic                                  s_axi_bready_in,
	// axi4-lite read address
	input  wire logic [ADDR_WIDTH-1:0]                 s_axi_araddr_in,
	input  wire logic                                  s_axi_arvalid_in,
	output logic                                       s_axi_arready_out,
	// axi4-lite read data
	output logic [31:0]                                s_axi_rdata_out,
	output logic [1:0]                                 s_axi_rresp_out,
	output logic                                       s_axi_rvalid_out,
	input  wire logic                                  s_axi_rready_in,
	// flags and address towards the rest of the unit
	output debug_flags_pkg::status_flags_type          status_flags_out,
	output logic [31:0]                                debug_address_out,
	// interrupt
	output logic                                       irq_out
);

	localparam int EVT_W = debug_flags_pkg::EVT_COUNT;

	typedef struct packed {
		debug_flags_pkg::status_flags_type flags;
		logic                              protected_state_loaded;
		logic [1:0]                        protected_state_wait;
		logic [EVT_W-1:0]                  irq_status;
		logic [EVT_W-1:0]                  irq_mask;
		logic [31:0]                       address;
		logic                              aw_full;
		logic [ADDR_WIDTH-1:0]             aw_addr;
		logic                              w_full;
		logic [31:0]                       w_data;
		logic [3:0]                        w_strb;
		logic                              aw_ready;
		logic                              w_ready;
		logic                              b_valid;
		logic [1:0]                        b_resp;
		logic                              ar_ready;
		logic                              r_valid;
		logic [31:0]                       r_data;
		logic [1:0]                        r_resp;
		logic                              irq;
	} block_state_type;

	block_state_type state;
	block_state_type next_state;

	logic [2:0]      sync_levels;
	logic            probe_seen;
	logic            protected_state_level;
	logic            swclk_changed;

	initial
	begin
		if (ADDR_WIDTH < 6 || ADDR_WIDTH > 10)
			$error("debug_status_flags: ADDR_WIDTH must lie in 6..10");
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin conditions pass two flip-flops first
	level_sync
	#(
		.WIDTH    (3)
	)
	u_pin_sync
	(
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.async_in ({swclk_function_changed_in, protected_device_in, probe_detected_in}),
		.sync_out (sync_levels)
	);

	assign probe_seen    = sync_levels[0];
	assign protected_state_level    = sync_levels[1];
	assign swclk_changed = sync_levels[2];

	////////////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_value,
		input logic [31:0] new_value, input logic [3:0] strb);
		logic [31:0] result;
		result = old_value;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				result[b*8 +: 8] = new_value[b*8 +: 8];
		end
		return result;
	endfunction : merge_bytes

	function automatic logic [31:0] status_word(input debug_flags_pkg::status_flags_type f);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[debug_flags_pkg::BIT_PROTECTED] = f.protected_state;
		w[debug_flags_pkg::BIT_PROBE]     = f.probe_present;
		w[debug_flags_pkg::BIT_DIRTY0]    = f.channel_dirty[0];
		w[debug_flags_pkg::BIT_DIRTY1]    = f.channel_dirty[1];
		w[debug_flags_pkg::BIT_HOT_PLUG]  = f.hot_plug_enabled;
		return w;
	endfunction : status_word

	////////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		logic [EVT_W-1:0]          events;
		logic [EVT_W-1:0]          w1c;
		logic [ADDR_WIDTH-3:0]     w_index;
		logic [ADDR_WIDTH-3:0]     r_index;
		logic                      do_write;
		events     = '0;
		w1c        = '0;
		w_index    = state.aw_addr[ADDR_WIDTH-1:2];
		r_index    = s_axi_araddr_in[ADDR_WIDTH-1:2];
		do_write   = 1'b0;
		next_state = state;

		// hot plug drops when the clock pin changes function; only reset raises it
		if (swclk_changed && state.flags.hot_plug_enabled)
		begin
			next_state.flags.hot_plug_enabled = 1'b0;
			events[debug_flags_pkg::EVT_HOT_PLUG_LOST] = 1'b1;
		end

		// probe presence is sticky with no clear path
		if (probe_seen && !state.flags.probe_present)
		begin
			next_state.flags.probe_present = 1'b1;
			events[debug_flags_pkg::EVT_PROBE] = 1'b1;
		end

		// protection is captured once after power-up, once the synchroniser has settled
		if (!state.protected_state_loaded)
		begin
			if (state.protected_state_wait == debug_flags_pkg::PROTECTED_STATE_CAPTURE_WAIT)
			begin
				next_state.flags.protected_state = protected_state_level;
				next_state.protected_state_loaded           = 1'b1;
			end
			else
				next_state.protected_state_wait = state.protected_state_wait + 2'h1;
		end

		// channel dirty: a write in the same cycle as a read wins
		for (int c = 0; c < debug_flags_pkg::CHANNEL_COUNT; c++)
		begin
			if (channel_strobe_in.write_strobe[c])
			begin
				next_state.flags.channel_dirty[c] = 1'b1;
				events[debug_flags_pkg::EVT_DIRTY0 + c] = 1'b1;
			end
			else if (channel_strobe_in.read_strobe[c])
				next_state.flags.channel_dirty[c] = 1'b0;
		end

		// write channel: address and data taken in either order
		if (s_axi_awvalid_in && state.aw_ready)
		begin
			next_state.aw_full = 1'b1;
			next_state.aw_addr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && state.w_ready)
		begin
			next_state.w_full = 1'b1;
			next_state.w_data = s_axi_wdata_in;
			next_state.w_strb = s_axi_wstrb_in;
		end
		if (state.b_valid && s_axi_bready_in)
			next_state.b_valid = 1'b0;

		if (state.aw_full && state.w_full && !state.b_valid)
		begin
			do_write           = 1'b1;
			next_state.aw_full = 1'b0;
			next_state.w_full  = 1'b0;
			next_state.b_valid = 1'b1;
			next_state.b_resp  = debug_flags_pkg::RESP_OKAY;
			case (w_index)
				debug_flags_pkg::IDX_STATUS_SECOND[ADDR_WIDTH-3:0]:
					next_state.b_resp = debug_flags_pkg::RESP_OKAY;
				debug_flags_pkg::IDX_DEBUG_ADDRESS[ADDR_WIDTH-3:0]:
					next_state.address = merge_bytes(state.address, state.w_data, state.w_strb);
				debug_flags_pkg::IDX_IRQ_STATUS[ADDR_WIDTH-3:0]:
					w1c = state.w_strb[0] ? state.w_data[EVT_W-1:0] : '0;
				debug_flags_pkg::IDX_IRQ_MASK[ADDR_WIDTH-3:0]:
				begin
					if (state.w_strb[0])
						next_state.irq_mask = state.w_data[EVT_W-1:0];
				end
				default:
					next_state.b_resp = debug_flags_pkg::RESP_SLVERR;
			endcase
		end

		// sticky events: a set in the clearing cycle survives
		next_state.irq_status = (state.irq_status & ~w1c) | events;

		// read channel: one outstanding read, answered the cycle after it is taken
		if (state.r_valid && s_axi_rready_in)
		begin
			next_state.r_valid  = 1'b0;
			next_state.ar_ready = 1'b1;
		end
		if (s_axi_arvalid_in && state.ar_ready)
		begin
			next_state.ar_ready = 1'b0;
			next_state.r_valid  = 1'b1;
			next_state.r_resp   = debug_flags_pkg::RESP_OKAY;
			case (r_index)
				debug_flags_pkg::IDX_STATUS_SECOND[ADDR_WIDTH-3:0]:
					next_state.r_data = status_word(state.flags);
				debug_flags_pkg::IDX_DEBUG_ADDRESS[ADDR_WIDTH-3:0]:
					next_state.r_data = state.address;
				debug_flags_pkg::IDX_IRQ_STATUS[ADDR_WIDTH-3:0]:
					next_state.r_data = {{(32-EVT_W){1'b0}}, state.irq_status};
				debug_flags_pkg::IDX_IRQ_MASK[ADDR_WIDTH-3:0]:
					next_state.r_data = {{(32-EVT_W){1'b0}}, state.irq_mask};
				default:
				begin
					next_state.r_data = 32'h0000_0000;
					next_state.r_resp = debug_flags_pkg::RESP_SLVERR;
				end
			endcase
		end

		// module reset spares the hot-plug, probe and protection flags
		if (module_reset_in)
		begin
			next_state.flags.channel_dirty = 2'h0;
			next_state.irq_status          = debug_flags_pkg::RESET_IRQ;
			next_state.irq_mask            = debug_flags_pkg::RESET_IRQ;
			next_state.address             = debug_flags_pkg::RESET_ADDRESS;
		end

		next_state.aw_ready = !next_state.aw_full && !(do_write && next_state.b_valid && state.b_valid);
		next_state.w_ready  = !next_state.w_full;
		next_state.irq      = |(next_state.irq_status & next_state.irq_mask);
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			state                        <= '0;
			state.flags.hot_plug_enabled <= debug_flags_pkg::RESET_HOT_PLUG;
			state.irq_status             <= debug_flags_pkg::RESET_IRQ;
			state.irq_mask               <= debug_flags_pkg::RESET_IRQ;
			state.address                <= debug_flags_pkg::RESET_ADDRESS;
			state.aw_ready               <= 1'b1;
			state.w_ready                <= 1'b1;
			state.ar_ready               <= 1'b1;
			state.b_resp                 <= debug_flags_pkg::RESP_OKAY;
			state.r_resp                 <= debug_flags_pkg::RESP_OKAY;
		end
		else
			state <= next_state;
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	assign s_axi_awready_out = state.aw_ready;
	assign s_axi_wready_out  = state.w_ready;
	assign s_axi_bvalid_out  = state.b_valid;
	assign s_axi_bresp_out   = state.b_resp;
	assign s_axi_arready_out = state.ar_ready;
	assign s_axi_rvalid_out  = state.r_valid;
	assign s_axi_rdata_out   = state.r_data;
	assign s_axi_rresp_out   = state.r_resp;
	assign status_flags_out  = state.flags;
	assign debug_address_out = state.address;
	assign irq_out           = state.irq;

endmodule : debug_status_flags

`default_nettype wire

// [debug_status_flags_props.sv]
// port assertions for the debug status flag block
`timescale 1ns/10ps
`default_nettype none

module debug_status_flags_props
(
	input wire logic                               clk_in,
	input wire logic                               rst_n_in,
	input wire logic                               module_reset_in,
	input wire logic                               probe_detected_in,
	input wire logic                               swclk_function_changed_in,
	input wire debug_flags_pkg::channel_strobe_type channel_strobe_in,
	input wire logic                               s_axi_awvalid_in,
	input wire logic                               s_axi_awready_out,
	input wire logic                               s_axi_wvalid_in,
	input wire logic                               s_axi_wready_out,
	input wire logic                               s_axi_bvalid_out,
	input wire logic                               s_axi_arvalid_in,
	input wire logic                               s_axi_arready_out,
	input wire logic                               s_axi_rvalid_out,
	input wire debug_flags_pkg::status_flags_type   status_flags_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_wr_taken;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid_in && s_axi_arready_out;
	endsequence

	a_dirty_set: assert property (channel_strobe_in.write_strobe[0] && !module_reset_in
		|=> status_flags_out.channel_dirty[0]) else $error("dirty flag 0 not set");
	a_dirty_clear: assert property (channel_strobe_in.read_strobe[1] && !channel_strobe_in.write_strobe[1]
		|=> !status_flags_out.channel_dirty[1]) else $error("dirty flag 1 not cleared");
	a_probe_set: assert property ($rose(probe_detected_in)
		|-> ##[1:4] status_flags_out.probe_present) else $error("probe flag not set");
	a_probe_stays: assert property (status_flags_out.probe_present
		|=> status_flags_out.probe_present) else $error("probe flag cleared");
	a_protected_state_stays: assert property (status_flags_out.protected_state
		|=> status_flags_out.protected_state) else $error("protected flag cleared");
	a_hot_plug_lost: assert property ($rose(swclk_function_changed_in)
		|-> ##[1:4] !status_flags_out.hot_plug_enabled) else $error("hot-plug flag not cleared");
	a_hot_plug_stays: assert property (!status_flags_out.hot_plug_enabled
		|=> !status_flags_out.hot_plug_enabled) else $error("hot-plug flag set again");
	a_write_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid_out) else $error("no write response");
	a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid_out) else $error("no read data");
endmodule : debug_status_flags_props

bind debug_status_flags debug_status_flags_props props (.clk_in, .rst_n_in, .module_reset_in,
	.probe_detected_in, .swclk_function_changed_in, .channel_strobe_in, .s_axi_awvalid_in,
	.s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_arvalid_in,
	.s_axi_arready_out, .s_axi_rvalid_out, .status_flags_out);
`default_nettype wire

// [level_sync.sv]
// two-stage synchroniser for asynchronous level inputs
`timescale 1ns/10ps
`default_nettype none

module level_sync
#(
	parameter int WIDTH = 1
)
(
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	// levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sync_state_type;

	sync_state_type state;
	sync_state_type next_state;

	initial
	begin
		if (WIDTH < 1)
			$error("level_sync: WIDTH must be at least 1");
	end

	// the first stage feeds only the second
	always_comb
	begin
		next_state.stage1 = async_in;
		next_state.stage2 = state.stage1;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			state <= '0;
		else
			state <= next_state;
	end

	assign sync_out = state.stage2;

endmodule : level_sync

`default_nettype wire

// [probe_model.sv]
// behavioural debug probe: presence and swclk pin function, with selectable lag
`timescale 1ns/10ps
`default_nettype none

module probe_model
(
	// clock
	input  wire logic       clk_in,
	// commands from the bench
	input  wire logic       attach_in,
	input  wire logic       pin_switch_in,
	input  wire logic [3:0] lag_in,
	// towards the block
	output logic            probe_detected_out,
	output logic            swclk_function_changed_out
);
	logic [3:0] count;

	initial
	begin
		count = 4'h0;
		probe_detected_out = 1'b0;
		swclk_function_changed_out = 1'b0;
	end

	// a change is passed on only after lag_in cycles, just after an edge
	always @(posedge clk_in)
	begin
		if ({attach_in, pin_switch_in} == {probe_detected_out, swclk_function_changed_out})
			count <= 4'h0;
		else if (count >= lag_in)
		begin
			probe_detected_out <= attach_in;
			swclk_function_changed_out <= pin_switch_in;
			count <= 4'h0;
		end
		else
			count <= count + 4'h1;
	end
endmodule : probe_model
`default_nettype wire

// [tb_debug_status_flags.sv]
// self-checking bench for the debug status flag block
`timescale 1ns/10ps
`default_nettype none

module tb_debug_status_flags;
	logic                                clk_in, rst_n_in, module_reset_in, protected_device_in;
	logic                                probe_w, swclk_w, attach, pin_switch, irq;
	logic [3:0]                          lag, wstrb;
	debug_flags_pkg::channel_strobe_type strobe;
	debug_flags_pkg::status_flags_type   flags;
	logic [7:0]                          awaddr, araddr;
	logic [31:0]                         wdata, rdata, addr_out, got, seed;
	logic                                awvalid, awready, wvalid, wready, bvalid, bready;
	logic                                arvalid, arready, rvalid, rready;
	logic [1:0]                          bresp, rresp, dirty;
	int                                  errors, cmp_count, cyc, i;

	initial
	begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end

	debug_status_flags #(.ADDR_WIDTH(8)) DUT (.clk_in, .rst_n_in, .module_reset_in,
		.probe_detected_in(probe_w), .protected_device_in, .swclk_function_changed_in(swclk_w),
		.channel_strobe_in(strobe), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
		.s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
		.s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.status_flags_out(flags), .debug_address_out(addr_out), .irq_out(irq));

	probe_model partner (.clk_in, .attach_in(attach), .pin_switch_in(pin_switch), .lag_in(lag),
		.probe_detected_out(probe_w), .swclk_function_changed_out(swclk_w));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xorshift

	// dirty flags after one strobe cycle: a write wins over a read
	function automatic logic [1:0] exp_dirty(input logic [1:0] d, input debug_flags_pkg::channel_strobe_type s);
		return (d & ~s.read_strobe) | s.write_strobe;
	endfunction : exp_dirty

	function automatic logic [31:0] st(input logic h, input logic [1:0] d, input logic p, input logic q);
		return {27'h0, h, d, p, q};
	endfunction : st

	function automatic logic [7:0] ba(input logic [7:0] x);
		return x << 2;
	endfunction : ba

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	////////////////////////////////////////////////////////////////////////////////
	// bus tasks: entered just after a rising edge, handshakes judged on values before the edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic pa, pw, ta, tw, tb;
		logic [1:0] r;
		pa = 1'b1;
		pw = 1'b1;
		tb = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (pa || pw)
		begin
			@(negedge clk_in);
			ta = awready;
			tw = wready;
			@(posedge clk_in);
			if (ta && pa)
				awvalid <= 1'b0;
			if (tw && pw)
				wvalid <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
		end
		bready <= 1'b1;
		while (!tb)
		begin
			@(negedge clk_in);
			tb = bvalid;
			r = bresp;
			@(posedge clk_in);
		end
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, r});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [1:0] er);
		logic t;
		logic [1:0] r;
		t = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		while (!t)
		begin
			@(negedge clk_in);
			t = arready;
			@(posedge clk_in);
		end
		arvalid <= 1'b0;
		rready <= 1'b1;
		t = 1'b0;
		while (!t)
		begin
			@(negedge clk_in);
			t = rvalid;
			got = rdata;
			r = rresp;
			@(posedge clk_in);
		end
		rready <= 1'b0;
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask : rd

	task automatic pulse(input logic [3:0] s);
		strobe <= s;
		@(posedge clk_in);
		strobe <= 4'h0;
		dirty = exp_dirty(dirty, s);
		@(negedge clk_in);
		chk("dirty", {30'h0, dirty}, {30'h0, flags.channel_dirty});
		@(posedge clk_in);
	endtask : pulse

	task automatic mod_reset();
		module_reset_in <= 1'b1;
		@(posedge clk_in);
		module_reset_in <= 1'b0;
		@(posedge clk_in);
		dirty = 2'b00;
	endtask : mod_reset

	always @(posedge clk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			errors++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		{rst_n_in, module_reset_in, attach, pin_switch, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, lag, strobe, dirty, errors, cmp_count, cyc} = '0;
		protected_device_in = 1'b1;
		wstrb = 4'hf;
		seed = 32'h30;
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		rd(ba(debug_flags_pkg::IDX_STATUS_SECOND), debug_flags_pkg::RESP_OKAY);
		chk("status reset", st(1'b1, 2'b00, 1'b0, 1'b1), got);
		rd(ba(debug_flags_pkg::IDX_DEBUG_ADDRESS), debug_flags_pkg::RESP_OKAY);
		chk("address reset", debug_flags_pkg::RESET_ADDRESS, got);
		rd(8'h30, debug_flags_pkg::RESP_SLVERR);
		chk("unmapped", 32'h0, got);
		for (i = 0; i < 40; i++)
		begin
			seed = xorshift(seed);
			pulse(seed[3:0]);
		end
		pulse(4'hf);
		wr(ba(debug_flags_pkg::IDX_STATUS_SECOND), 32'h0, debug_flags_pkg::RESP_OKAY);
		rd(ba(debug_flags_pkg::IDX_STATUS_SECOND), debug_flags_pkg::RESP_OKAY);
		chk("status kept", st(1'b1, dirty, 1'b0, 1'b1), got);
		// interrupt: raise, clear, mask
		wr(ba(debug_flags_pkg::IDX_IRQ_MASK), 32'h4, debug_flags_pkg::RESP_OKAY);
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(ba(debug_flags_pkg::IDX_IRQ_STATUS), 32'hf, debug_flags_pkg::RESP_OKAY);
		chk("irq cleared", 32'h0, {31'h0, irq});
		pulse(4'h4);
		chk("irq event", 32'h1, {31'h0, irq});
		wr(ba(debug_flags_pkg::IDX_IRQ_STATUS), 32'h4, debug_flags_pkg::RESP_OKAY);
		wr(ba(debug_flags_pkg::IDX_IRQ_MASK), 32'h0, debug_flags_pkg::RESP_OKAY);
		pulse(4'h4);
		chk("irq masked", 32'h0, {31'h0, irq});
		// slow probe attaches, then leaves
		lag <= 4'h5;
		attach <= 1'b1;
		repeat (12) @(posedge clk_in);
		chk("probe set", 32'h1, {31'h0, flags.probe_present});
		attach <= 1'b0;
		repeat (12) @(posedge clk_in);
		chk("probe kept", 32'h1, {31'h0, flags.probe_present});
		seed = xorshift(seed);
		wr(ba(debug_flags_pkg::IDX_DEBUG_ADDRESS), seed, debug_flags_pkg::RESP_OKAY);
		rd(ba(debug_flags_pkg::IDX_DEBUG_ADDRESS), debug_flags_pkg::RESP_OKAY);
		chk("address", seed, got);
		wstrb <= 4'h1;
		wr(ba(debug_flags_pkg::IDX_DEBUG_ADDRESS), 32'h0, debug_flags_pkg::RESP_OKAY);
		wstrb <= 4'hf;
		chk("address lane 0", {seed[31:8], 8'h00}, addr_out);
		mod_reset();
		chk("flags after module reset", st(1'b1, 2'b00, 1'b1, 1'b1), {27'h0, flags});
		chk("address after module reset", debug_flags_pkg::RESET_ADDRESS, addr_out);
		// prompt pin switch clears hot-plug until the next external reset
		lag <= 4'h0;
		pin_switch <= 1'b1;
		repeat (6) @(posedge clk_in);
		chk("hot-plug lost", 32'h0, {31'h0, flags.hot_plug_enabled});
		pin_switch <= 1'b0;
		repeat (6) @(posedge clk_in);
		mod_reset();
		wr(ba(debug_flags_pkg::IDX_STATUS_SECOND), 32'hff, debug_flags_pkg::RESP_OKAY);
		rd(ba(debug_flags_pkg::IDX_STATUS_SECOND), debug_flags_pkg::RESP_OKAY);
		chk("status no hot-plug", st(1'b0, 2'b00, 1'b1, 1'b1), got);
		rst_n_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		rd(ba(debug_flags_pkg::IDX_STATUS_SECOND), debug_flags_pkg::RESP_OKAY);
		chk("status after reset", st(1'b1, 2'b00, 1'b0, 1'b1), got);
		stop_test();
	end
endmodule : tb_debug_status_flags
`default_nettype wire
